// File: hdl/epi_pkg.sv
// Operation
// - A first word decodes as an extended operation only while the synchronised enable bit is set.
// - Add unsigned 6-bit literal to the selected pointer, write sum back.
// - Pointer field of 3 means add-and-return on the frame pointer.
// - Add-and-return pops the return stack top into the program counter.
// - Add-and-return takes two cycles; the second one is idle.
// - Call via working register pushes program counter plus 2 first.
// - Call via working register loads working register into counter low.
// - Call loads high latch into counter high, upper latch into upper.
// - Call via working register takes two cycles; second one is idle.
// - Call via working register saves no working, status or bank copy.
// - Word 0000 0000 0001 0100 is the call via working register.
// - Move source address is frame pointer plus 7-bit first-word offset.
// - Move destination is 12-bit literal of second word; byte copied.
// - Both move addresses may lie anywhere from 000h to fffh.
// - A move source on an indirect register reads as 00h.
`default_nettype none

package epi_pkg;

  // ---------------------------------------------------------------
  // Instruction cycle phases
  // ---------------------------------------------------------------
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_PTR = 8'he8;
  localparam logic [7:0] OPC_MOVE_IDX = 8'heb;
  localparam logic [15:0] OPC_CALL_W = 16'h0014;
  localparam logic [3:0] OPC_SECOND_WORD = 4'hf;
  localparam logic [1:0] SEL_FRAME_RET = 2'h3;
  localparam int PTR_SEL_LSB = 6;
  localparam int LIT_WIDTH = 6;
  localparam int OFS_WIDTH = 7;
  localparam int MOVE_KIND_BIT = 7;
  localparam int OPC_HI_LSB = 8;
  localparam int SECOND_TAG_LSB = 12;
  localparam int ADDR_WIDTH = 12;
  localparam int FRAME_IDX = 2;
  localparam logic [20:0] PC_STEP = 21'h2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] INDIRECT_READ = 8'h00;

  // ---------------------------------------------------------------
  // Indirect register windows: each base and the four addresses below it
  // ---------------------------------------------------------------
  localparam logic [11:0] IND_TOP0 = 12'hfef;
  localparam logic [11:0] IND_TOP1 = 12'hfe7;
  localparam logic [11:0] IND_TOP2 = 12'hfdf;
  localparam logic [11:0] IND_SPAN = 12'h004;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_IDLE = 3'b010,
    ST_MOVE2 = 3'b100
  } epi_state_t;

  // Operation carried in the current instruction cycle
  typedef enum logic [6:0] {
    OP_NONE = 7'b0000001,
    OP_ADD_PTR = 7'b0000010,
    OP_ADD_RET = 7'b0000100,
    OP_CALL_W = 7'b0001000,
    OP_MOVE1 = 7'b0010000,
    OP_MOVE2 = 7'b0100000,
    OP_NOP = 7'b1000000
  } epi_op_t;

endpackage : epi_pkg

`default_nettype wire

// File: hdl/epi_exec.sv
`default_nettype none

module epi_exec
  import epi_pkg::*;
#(
  parameter int PC_WIDTH = 21
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic extendedSetEnable,
  input wire logic [15:0] instrWord,
  input wire logic [PC_WIDTH-1:0] pcIn,
  input wire logic [7:0] workingRegister,
  input wire logic [7:0] counterHighLatch,
  input wire logic [PC_WIDTH-17:0] counterUpperLatch,
  input wire logic [PC_WIDTH-1:0] topOfReturnStack,
  input wire logic [7:0] dmemRdData,
  output logic claimed,
  output logic [1:0] phase,
  output logic [ADDR_WIDTH-1:0] pointer0,
  output logic [ADDR_WIDTH-1:0] pointer1,
  output logic [ADDR_WIDTH-1:0] framePointer,
  output logic stackPush,
  output logic [PC_WIDTH-1:0] stackPushValue,
  output logic stackPop,
  output logic pcLoad,
  output logic [PC_WIDTH-1:0] pcLoadValue,
  output logic dmemRdEn,
  output logic [ADDR_WIDTH-1:0] dmemRdAddr,
  output logic dmemWrEn,
  output logic [ADDR_WIDTH-1:0] dmemWrAddr,
  output logic [7:0] dmemWrData
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // True when an address falls in one of the indirect windows
  function automatic logic isIndirect(input logic [ADDR_WIDTH-1:0] a);
    isIndirect = ((a <= IND_TOP0) && (a >= IND_TOP0 - IND_SPAN)) ||
                 ((a <= IND_TOP1) && (a >= IND_TOP1 - IND_SPAN)) ||
                 ((a <= IND_TOP2) && (a >= IND_TOP2 - IND_SPAN));
  endfunction : isIndirect

  // Classify a first word of an instruction
  function automatic epi_op_t decodeFirst(input logic [15:0] w);
    if (w == OPC_CALL_W) begin
      decodeFirst = OP_CALL_W;
    end else if (w[15:OPC_HI_LSB] == OPC_ADD_PTR) begin
      if (w[PTR_SEL_LSB+1:PTR_SEL_LSB] == SEL_FRAME_RET) begin
        decodeFirst = OP_ADD_RET;
      end else begin
        decodeFirst = OP_ADD_PTR;
      end
    end else if (w[15:OPC_HI_LSB] == OPC_MOVE_IDX && !w[MOVE_KIND_BIT]) begin
      decodeFirst = OP_MOVE1;
    end else begin
      decodeFirst = OP_NONE;
    end
  endfunction : decodeFirst

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic enableMeta_r;
  logic enable_r;
  logic [1:0] phase_r;
  epi_state_t state_r;
  epi_op_t op_r;
  logic [15:0] word_r;
  logic [ADDR_WIDTH-1:0] ptr_r [3];
  logic [7:0] moveData_r;
  logic stackPush_r;
  logic [PC_WIDTH-1:0] stackPushValue_r;
  logic stackPop_r;
  logic pcLoad_r;
  logic [PC_WIDTH-1:0] pcLoadValue_r;
  logic dmemRdEn_r;
  logic [ADDR_WIDTH-1:0] dmemRdAddr_r;
  logic dmemWrEn_r;
  logic [ADDR_WIDTH-1:0] dmemWrAddr_r;
  logic [1:0] ptrSel;
  logic [ADDR_WIDTH-1:0] literalExt;

  assign ptrSel = word_r[PTR_SEL_LSB+1:PTR_SEL_LSB];
  assign literalExt = {{(ADDR_WIDTH-LIT_WIDTH){1'b0}},
                       word_r[LIT_WIDTH-1:0]};

  // ---------------------------------------------------------------
  // Enable bit and phase counter
  // ---------------------------------------------------------------
  // Config bit comes from fuse logic; synchronised to be safe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enableMeta_r <= 1'b0;
      enable_r <= 1'b0;
    end else begin
      enableMeta_r <= extendedSetEnable;
      enable_r <= enableMeta_r;
    end
  end

  // Four clocks make one instruction cycle, free running
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Decode at the end of Q1
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_r <= WORD_RESET;
      op_r <= OP_NONE;
    end else if (phase_r == PH_Q1) begin
      word_r <= instrWord;
      case (state_r)
        ST_IDLE: op_r <= OP_NOP;
        ST_MOVE2: begin
          // A malformed second word is dropped as a no-operation
          if (instrWord[15:SECOND_TAG_LSB] == OPC_SECOND_WORD) begin
            op_r <= OP_MOVE2;
          end else begin
            op_r <= OP_NOP;
          end
        end
        default: op_r <= enable_r ? decodeFirst(instrWord) : OP_NONE;
      endcase
    end
  end

  // Sequencer advances at the end of Q4
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_EXEC;
    end else if (phase_r == PH_Q4) begin
      case (op_r)
        OP_ADD_RET: state_r <= ST_IDLE;
        OP_CALL_W: state_r <= ST_IDLE;
        OP_MOVE1: state_r <= ST_MOVE2;
        default: state_r <= ST_EXEC;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pointer update in Q4; only the pointer changes, never flags
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : gPtr
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ptr_r[i] <= PTR_RESET;
      end else if (phase_r == PH_Q4) begin
        if (op_r == OP_ADD_PTR && ptrSel == 2'(i)) begin
          ptr_r[i] <= ptr_r[i] + literalExt;
        end else if (op_r == OP_ADD_RET && i == FRAME_IDX) begin
          ptr_r[i] <= ptr_r[i] + literalExt;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Return stack and program counter strobes
  // ---------------------------------------------------------------
  // Push lands in Q3; only the return address goes, no shadow copies
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stackPush_r <= 1'b0;
      stackPushValue_r <= '0;
    end else begin
      stackPush_r <= (phase_r == PH_Q2) && (op_r == OP_CALL_W);
      if (phase_r == PH_Q2 && op_r == OP_CALL_W) begin
        stackPushValue_r <= pcIn + PC_STEP[PC_WIDTH-1:0];
      end
    end
  end

  // Counter load and pop in Q4, alongside the pointer add
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcLoad_r <= 1'b0;
      stackPop_r <= 1'b0;
      pcLoadValue_r <= '0;
    end else begin
      pcLoad_r <= (phase_r == PH_Q3) &&
                  (op_r == OP_ADD_RET || op_r == OP_CALL_W);
      stackPop_r <= (phase_r == PH_Q3) && (op_r == OP_ADD_RET);
      if (phase_r == PH_Q3 && op_r == OP_ADD_RET) begin
        pcLoadValue_r <= topOfReturnStack;
      end else if (phase_r == PH_Q3 && op_r == OP_CALL_W) begin
        // Old low byte is simply overwritten
        pcLoadValue_r <= {counterUpperLatch, counterHighLatch,
                          workingRegister};
      end
    end
  end

  // ---------------------------------------------------------------
  // Indexed to file move
  // ---------------------------------------------------------------
  // Source address is formed in Q2 so the read can sit in Q4
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dmemRdEn_r <= 1'b0;
      dmemRdAddr_r <= PTR_RESET;
    end else begin
      dmemRdEn_r <= (phase_r == PH_Q3) && (op_r == OP_MOVE1);
      if (phase_r == PH_Q2 && op_r == OP_MOVE1) begin
        // Wraps within 12 bits, so any address is reachable
        dmemRdAddr_r <= ptr_r[FRAME_IDX] +
                        {{(ADDR_WIDTH-OFS_WIDTH){1'b0}},
                         word_r[OFS_WIDTH-1:0]};
      end
    end
  end

  // Read data is taken at the end of Q4 of the first cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      moveData_r <= BYTE_RESET;
    end else if (dmemRdEn_r && phase_r == PH_Q4) begin
      moveData_r <= isIndirect(dmemRdAddr_r) ? INDIRECT_READ
                                             : dmemRdData;
    end
  end

  // Destination write in Q4 of the second cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dmemWrEn_r <= 1'b0;
      dmemWrAddr_r <= PTR_RESET;
    end else begin
      dmemWrEn_r <= (phase_r == PH_Q3) && (op_r == OP_MOVE2);
      if (phase_r == PH_Q2 && op_r == OP_MOVE2) begin
        // Counter low and stack top bytes are not guarded here
        dmemWrAddr_r <= word_r[ADDR_WIDTH-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign claimed = (op_r != OP_NONE);
  assign phase = phase_r;
  assign pointer0 = ptr_r[0];
  assign pointer1 = ptr_r[1];
  assign framePointer = ptr_r[FRAME_IDX];
  assign stackPush = stackPush_r;
  assign stackPushValue = stackPushValue_r;
  assign stackPop = stackPop_r;
  assign pcLoad = pcLoad_r;
  assign pcLoadValue = pcLoadValue_r;
  assign dmemRdEn = dmemRdEn_r;
  assign dmemRdAddr = dmemRdAddr_r;
  assign dmemWrEn = dmemWrEn_r;
  assign dmemWrAddr = dmemWrAddr_r;
  assign dmemWrData = moveData_r;

endmodule : epi_exec

`default_nettype wire

// File: dv/epi_exec_props.sv
`default_nettype none
// ----
// Port checker
// ----
module epi_exec_props
  import epi_pkg::*;
#(
  parameter int PC_WIDTH = 21
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic extendedSetEnable,
  input wire logic [15:0] instrWord,
  input wire logic [PC_WIDTH-1:0] pcIn,
  input wire logic [7:0] workingRegister,
  input wire logic [7:0] counterHighLatch,
  input wire logic [PC_WIDTH-17:0] counterUpperLatch,
  input wire logic [PC_WIDTH-1:0] topOfReturnStack,
  input wire logic [7:0] dmemRdData,
  input wire logic claimed,
  input wire logic [ADDR_WIDTH-1:0] pointer0,
  input wire logic [ADDR_WIDTH-1:0] framePointer,
  input wire logic stackPush,
  input wire logic [PC_WIDTH-1:0] stackPushValue,
  input wire logic stackPop,
  input wire logic pcLoad,
  input wire logic [PC_WIDTH-1:0] pcLoadValue,
  input wire logic dmemRdEn,
  input wire logic [ADDR_WIDTH-1:0] dmemRdAddr,
  input wire logic dmemWrEn,
  input wire logic [ADDR_WIDTH-1:0] dmemWrAddr,
  input wire logic [7:0] dmemWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lowCnt_r;
  logic rdInd;
  // 15 low cycles outlast the sync flops plus the longest claim
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lowCnt_r <= 4'h0;
    end else if (extendedSetEnable) begin
      lowCnt_r <= 4'h0;
    end else if (lowCnt_r != 4'hf) begin
      lowCnt_r <= lowCnt_r + 4'h1;
    end
  end
  // Source inside one of the indirect windows
  assign rdInd = (dmemRdAddr <= IND_TOP0 && dmemRdAddr >= IND_TOP0 - IND_SPAN)
    || (dmemRdAddr <= IND_TOP1 && dmemRdAddr >= IND_TOP1 - IND_SPAN)
    || (dmemRdAddr <= IND_TOP2 && dmemRdAddr >= IND_TOP2 - IND_SPAN);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  enable_gate_a: assert property (
    lowCnt_r == 4'hf |-> !claimed && !dmemWrEn && !pcLoad)
    else $error("claim while disabled");
  ptr_add_a: assert property (
    $changed(pointer0) |->
      pointer0 == $past(pointer0) + 12'($past(instrWord[5:0], 4)))
    else $error("pointer sum wrong");
  pop_load_a: assert property (
    stackPop |-> pcLoad && pcLoadValue == $past(topOfReturnStack))
    else $error("return target wrong");
  idle_after_a: assert property (
    pcLoad |=> (claimed && !stackPush && !pcLoad && !dmemRdEn)[*4])
    else $error("second cycle not idle");
  push_value_a: assert property (
    stackPush |-> stackPushValue == PC_WIDTH'($past(pcIn) + PC_WIDTH'(2)))
    else $error("pushed address wrong");
  call_target_a: assert property (
    stackPush |=> pcLoad && !stackPop && pcLoadValue == {$past(
      counterUpperLatch), $past(counterHighLatch), $past(workingRegister)})
    else $error("call target wrong");
  read_addr_a: assert property (
    dmemRdEn |-> dmemRdAddr == framePointer + 12'($past(instrWord[6:0], 3)))
    else $error("source address wrong");
  read_data_a: assert property (
    dmemRdEn |=> dmemWrData == ($past(rdInd) ? 8'h00 : $past(dmemRdData)))
    else $error("moved byte wrong");
  move_write_a: assert property (
    dmemWrEn |-> $past(instrWord, 3) == {4'hf, dmemWrAddr})
    else $error("destination wrong");
  cover property (stackPush);
  cover property (stackPop);
  cover property (dmemWrEn);
endmodule : epi_exec_props
bind epi_exec epi_exec_props #(.PC_WIDTH(PC_WIDTH)) props_u (
  .mclk(mclk),
  .rst(rst),
  .extendedSetEnable(extendedSetEnable),
  .instrWord(instrWord),
  .pcIn(pcIn),
  .workingRegister(workingRegister),
  .counterHighLatch(counterHighLatch),
  .counterUpperLatch(counterUpperLatch),
  .topOfReturnStack(topOfReturnStack),
  .dmemRdData(dmemRdData),
  .claimed(claimed),
  .pointer0(pointer0),
  .framePointer(framePointer),
  .stackPush(stackPush),
  .stackPushValue(stackPushValue),
  .stackPop(stackPop),
  .pcLoad(pcLoad),
  .pcLoadValue(pcLoadValue),
  .dmemRdEn(dmemRdEn),
  .dmemRdAddr(dmemRdAddr),
  .dmemWrEn(dmemWrEn),
  .dmemWrAddr(dmemWrAddr),
  .dmemWrData(dmemWrData)
);
`default_nettype wire

// File: dv/epi_mem_model.sv
`default_nettype none
// ----
// Data memory partner
// ----
module epi_mem_model (
  input wire logic mclk,
  input wire logic dmemRdEn,
  input wire logic [11:0] dmemRdAddr,
  output logic [7:0] dmemRdData,
  input wire logic dmemWrEn,
  input wire logic [11:0] dmemWrAddr,
  input wire logic [7:0] dmemWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  // Known pattern so each address within a 256-byte page reads back distinct
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h3c;
  end
  // Unselected read shows the inverse, so a stray sample is caught
  assign dmemRdData = dmemRdEn ? mem[dmemRdAddr] : ~mem[dmemRdAddr];
  always @(posedge mclk) begin
    if (dmemWrEn) mem[dmemWrAddr] <= dmemWrData;
  end
endmodule : epi_mem_model
`default_nettype wire

// File: dv/epi_exec_test.sv
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
// ----
// Testbench
// ----
module epi_exec_test
  import epi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, extendedSetEnable, claimed, stackPush, stackPop, pcLoad;
  logic dmemRdEn, dmemWrEn;
  logic [15:0] instrWord;
  logic [20:0] pcIn, topOfReturnStack, stackPushValue, pcLoadValue;
  logic [7:0] workingRegister, counterHighLatch, dmemRdData, dmemWrData;
  logic [4:0] counterUpperLatch;
  logic [1:0] phase;
  logic [11:0] pointer0, pointer1, framePointer, dmemRdAddr, dmemWrAddr;
  int err_total, checks;
  epi_exec dut_u (
    .mclk(mclk),
    .rst(rst),
    .extendedSetEnable(extendedSetEnable),
    .instrWord(instrWord),
    .pcIn(pcIn),
    .workingRegister(workingRegister),
    .counterHighLatch(counterHighLatch),
    .counterUpperLatch(counterUpperLatch),
    .topOfReturnStack(topOfReturnStack),
    .dmemRdData(dmemRdData),
    .claimed(claimed),
    .phase(phase),
    .pointer0(pointer0),
    .pointer1(pointer1),
    .framePointer(framePointer),
    .stackPush(stackPush),
    .stackPushValue(stackPushValue),
    .stackPop(stackPop),
    .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue),
    .dmemRdEn(dmemRdEn),
    .dmemRdAddr(dmemRdAddr),
    .dmemWrEn(dmemWrEn),
    .dmemWrAddr(dmemWrAddr),
    .dmemWrData(dmemWrData)
  );
  epi_mem_model mem_u (
    .mclk(mclk),
    .dmemRdEn(dmemRdEn),
    .dmemRdAddr(dmemRdAddr),
    .dmemRdData(dmemRdData),
    .dmemWrEn(dmemWrEn),
    .dmemWrAddr(dmemWrAddr),
    .dmemWrData(dmemWrData)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic nb(input int n);
    repeat (n) @(negedge mclk);
  endtask : nb
  // Word goes out in phase 0; bounded so a stuck phase counter ends the run
  task automatic word(input logic [15:0] w);
    for (int i = 0; phase !== PH_Q1; i++) begin
      if (i > 8) begin
        err_total++;
        report_and_stop();
      end
      nb(1);
    end
    instrWord = w;
  endtask : word
  task automatic t_add_ret();
    topOfReturnStack = 21'h1abcd;
    word({OPC_ADD_PTR, SEL_FRAME_RET, 6'h05});
    nb(3);
    `CHK("pop", 1'b1, stackPop)
    `CHK("pcval", 21'h1abcd, pcLoadValue)
    nb(1);
    instrWord = {OPC_ADD_PTR, 8'h01};
    nb(1);
    `CHK("idle", 1'b1, claimed)
    nb(3);
    `CHK("frame", 12'h044, framePointer)
    `CHK("ptr0", 12'h03f, pointer0)
  endtask : t_add_ret
  task automatic t_call();
    pcIn = 21'h000100;
    workingRegister = 8'h06;
    counterHighLatch = 8'h10;
    counterUpperLatch = 5'h03;
    word(OPC_CALL_W);
    nb(2);
    `CHK("pushval", 21'h000102, stackPushValue)
    nb(1);
    `CHK("pcval", 21'h031006, pcLoadValue)
    nb(1);
    // A word offered in the idle cycle must be ignored
    instrWord = {OPC_ADD_PTR, 8'h01};
    nb(1);
    `CHK("idle", 1'b1, claimed)
    nb(3);
    `CHK("ptr0", 12'h03f, pointer0)
  endtask : t_call
  task automatic t_move(input logic [6:0] z, input logic [15:0] w2,
      input logic [11:0] src, input logic [7:0] d, input logic wr);
    word({OPC_MOVE_IDX, 1'b0, z});
    nb(3);
    `CHK("rdaddr", src, dmemRdAddr)
    nb(1);
    instrWord = w2;
    nb(3);
    `CHK("wren", wr, dmemWrEn)
    nb(1);
    if (wr) `CHK("dest", d, mem_u.mem[w2[11:0]])
  endtask : t_move
  initial begin
    rst = 1'b1;
    extendedSetEnable = 1'b0;
    instrWord = 16'h0000;
    pcIn = 21'h000000;
    topOfReturnStack = 21'h000000;
    workingRegister = 8'h00;
    counterHighLatch = 8'h00;
    counterUpperLatch = 5'h00;
    nb(5);
    rst = 1'b0;
    word({OPC_ADD_PTR, 8'h05});
    // Several refused cycles, long enough for the disabled-gate check
    nb(20);
    `CHK("ptr0", 12'h000, pointer0)
    `CHK("claim", 1'b0, claimed)
    extendedSetEnable = 1'b1;
    nb(4);
    // Each pointer gets the largest literal once
    for (int f = 0; f < 3; f++) begin
      word({OPC_ADD_PTR, f[1:0], 6'h3f});
      nb(4);
    end
    `CHK("ptr1", 12'h03f, pointer1)
    t_add_ret();
    t_call();
    // Destinations avoid the counter and stack bytes
    t_move(7'h7f, 16'hf123, 12'h0c3, 8'hff, 1'b1);
    t_move(7'h00, 16'ha456, 12'h044, 8'h00, 1'b0);
    for (int n = 0; n < 63; n++) begin
      word({OPC_ADD_PTR, 2'h2, 6'h3f});
      nb(4);
    end
    t_move(7'h28, 16'hf000, 12'hfed, 8'h00, 1'b1);
    report_and_stop();
  end
endmodule : epi_exec_test
`default_nettype wire
